/* rtl/ddem_pkg.sv */
// Purpose: Shared constants and types of the drive diagnostic and error manager
// Assumes: One core clock, synchronous active-high reset
// Notes:   Diagnostic parameters are addressed by their service-channel ident number

package ddem_pkg;

   // Service-channel ident numbers
   localparam logic [15:0] IDN_SEVERE     = 16'h000B;
   localparam logic [15:0] IDN_WARN       = 16'h000C;
   localparam logic [15:0] IDN_INFO       = 16'h000D;
   localparam logic [15:0] IDN_IFACE      = 16'h000E;
   localparam logic [15:0] IDN_DIAG       = 16'h005F;
   localparam logic [15:0] IDN_MASK_WARN  = 16'h0061;
   localparam logic [15:0] IDN_MASK_INFO  = 16'h0062;
   localparam logic [15:0] IDN_ERR_RESET  = 16'h0063;
   localparam logic [15:0] IDN_VENDOR     = 16'h0081;
   localparam logic [15:0] IDN_STATUS     = 16'h0087;

   // Status word bit positions
   localparam int STS_SEVERE_CHG_BIT = 11;
   localparam int STS_WARN_CHG_BIT   = 12;
   localparam int STS_INFO_CHG_BIT   = 13;
   localparam int STS_SHUTDOWN_BIT   = 13;

   // Class field layouts
   localparam int          CLASS_COMM_BIT     = 12;
   localparam logic [15:0] SEVERE_MAPPED_MASK = 16'h3BB7;
   localparam logic [15:0] CLASS_VENDOR_MASK  = 16'h8000;
   localparam logic [15:0] VENDOR_GENERAL     = 16'h0001;
   localparam logic [15:0] IFACE_COMM_FAULT   = 16'h0001;

   // Reset values
   localparam logic [15:0] CLASS_RESET = 16'h0000;
   localparam logic [15:0] MASK_RESET  = 16'hFFFF;

   // Error-reset procedure command
   localparam logic [1:0] CMD_START = 2'h3;
   localparam logic [1:0] CMD_IDLE  = 2'h0;
   localparam logic [1:0] CMD_DONE  = 2'h1;
   localparam logic [1:0] CMD_FAIL  = 2'h2;

   typedef enum logic [1:0] {
      DDEM_RUN   = 2'h0,
      DDEM_BRAKE = 2'h1,
      DDEM_OFF   = 2'h3
   } ddem_state_t;

endpackage

/* rtl/ddem_shutdown.sv */
// Purpose: Shut-down sequencer: quick stop, then power stage off
// Assumes: Fault and standstill come from logic on the core clock
// Notes:   Leaves the off state only on a successful error reset
`timescale 1ns/10ps

module ddem_shutdown
   import ddem_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_srst,
   input  wire logic i_fault,
   input  wire logic i_standstill,
   input  wire logic i_release,
   output logic      o_quick_stop,
   output logic      o_power_en,
   output logic      o_shutdown
);

   ddem_state_t state_ff;
   ddem_state_t nxt_state;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         DDEM_RUN: begin
            // An error reset taken in the same cycle wins over the stale fault
            if (i_fault & ~i_release) begin
               nxt_state = DDEM_BRAKE;
            end
         end
         DDEM_BRAKE: begin
            if (i_release) begin
               nxt_state = DDEM_RUN;
            end else if (i_standstill) begin
               nxt_state = DDEM_OFF;
            end
         end
         DDEM_OFF: begin
            if (i_release) begin
               nxt_state = DDEM_RUN;
            end
         end
         default: begin
            nxt_state = DDEM_OFF;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_ff     <= DDEM_RUN;
         o_quick_stop <= 1'b0;
         o_power_en   <= 1'b1;
         o_shutdown   <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         o_quick_stop <= (nxt_state == DDEM_BRAKE);
         o_power_en   <= (nxt_state != DDEM_OFF);
         o_shutdown   <= (nxt_state != DDEM_RUN);
      end
   end

endmodule // ddem_shutdown

/* rtl/ddem_top.sv */
// Purpose: Diagnostic classes, change bits and error reset of a servo drive
// Assumes: Cause inputs come from drive logic on the core clock
// Notes:   Service channel answers one cycle after each request
`timescale 1ns/10ps

module ddem_top
   import ddem_pkg::*;
(
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_SRST,
   input  wire logic        I_SC_REQ,
   input  wire logic        I_SC_WR,
   input  wire logic [15:0] I_SC_IDN,
   input  wire logic [15:0] I_SC_WDATA,
   input  wire logic [15:0] I_ERR_CAUSE,
   input  wire logic        I_VENDOR_FAULT,
   input  wire logic [15:0] I_ERR_CODE,
   input  wire logic [15:0] I_WARN_CAUSE,
   input  wire logic        I_VENDOR_WARN,
   input  wire logic [15:0] I_INFO_COND,
   input  wire logic        I_VENDOR_INFO,
   input  wire logic        I_STANDSTILL,
   output logic             O_SC_ACK,
   output logic      [15:0] O_SC_RDATA,
   output logic             O_SC_ERR,
   output logic      [15:0] O_STATUS_WORD,
   output logic      [1:0]  O_CMD_STATUS,
   output logic             O_QUICK_STOP,
   output logic             O_POWER_EN
);

   // Register state
   logic [15:0] severe_ff;
   logic [15:0] vendor_ff;
   logic [15:0] iface_ff;
   logic [15:0] diag_ff;
   logic [15:0] warn_ff;
   logic [15:0] info_ff;
   logic [15:0] mask_warn_ff;
   logic [15:0] mask_info_ff;
   logic [1:0]  cmd_ff;
   logic        severe_chg_ff;
   logic        warn_chg_ff;
   logic        info_chg_ff;

   // Next values
   logic [15:0] nxt_severe;
   logic [15:0] nxt_vendor;
   logic [15:0] nxt_iface;
   logic [15:0] nxt_diag;
   logic [15:0] nxt_warn;
   logic [15:0] nxt_info;
   logic [15:0] nxt_mask_warn;
   logic [15:0] nxt_mask_info;
   logic [1:0]  nxt_cmd;
   logic        nxt_severe_chg;
   logic        nxt_warn_chg;
   logic        nxt_info_chg;
   logic [15:0] nxt_status;

   // Service-channel decode
   logic        rd_req;
   logic        wr_req;
   logic        hit_severe;
   logic        hit_warn;
   logic        hit_info;
   logic        hit_iface;
   logic        hit_diag;
   logic        hit_mask_warn;
   logic        hit_mask_info;
   logic        hit_err_reset;
   logic        hit_vendor;
   logic        hit_status;
   logic        rd_hit;
   logic        wr_hit;
   logic [15:0] rd_val;
   logic        rd_warn;
   logic        rd_info;

   // Error reset procedure
   logic        reset_start;
   logic        reset_cancel;
   logic        cause_live;
   logic        reset_ok;
   logic        reset_refused;

   // Class inputs and events
   logic [15:0] vendor_set;
   logic [15:0] severe_set;
   logic [15:0] iface_set;
   logic [15:0] warn_in;
   logic [15:0] info_in;
   logic        severe_evt;
   logic        warn_evt;
   logic        info_evt;
   logic        first_error;
   logic        shutdown;
   logic        shutdown_next;

   assign rd_req = I_SC_REQ & ~I_SC_WR;
   assign wr_req = I_SC_REQ & I_SC_WR;

   assign hit_severe    = (I_SC_IDN == IDN_SEVERE);
   assign hit_warn      = (I_SC_IDN == IDN_WARN);
   assign hit_info      = (I_SC_IDN == IDN_INFO);
   assign hit_iface     = (I_SC_IDN == IDN_IFACE);
   assign hit_diag      = (I_SC_IDN == IDN_DIAG);
   assign hit_mask_warn = (I_SC_IDN == IDN_MASK_WARN);
   assign hit_mask_info = (I_SC_IDN == IDN_MASK_INFO);
   assign hit_err_reset = (I_SC_IDN == IDN_ERR_RESET);
   assign hit_vendor    = (I_SC_IDN == IDN_VENDOR);
   assign hit_status    = (I_SC_IDN == IDN_STATUS);

   assign rd_hit = hit_severe | hit_warn | hit_info | hit_iface | hit_diag
                 | hit_mask_warn | hit_mask_info | hit_err_reset
                 | hit_vendor | hit_status;

   // Only masks and the reset command take writes; classes are read-only
   assign wr_hit = hit_mask_warn | hit_mask_info | hit_err_reset;

   assign rd_val = hit_severe    ? severe_ff :
                   hit_warn      ? warn_ff :
                   hit_info      ? info_ff :
                   hit_iface     ? iface_ff :
                   hit_diag      ? diag_ff :
                   hit_mask_warn ? mask_warn_ff :
                   hit_mask_info ? mask_info_ff :
                   hit_err_reset ? {14'h0000, cmd_ff} :
                   hit_vendor    ? vendor_ff :
                   hit_status    ? O_STATUS_WORD :
                   16'h0000;

   assign rd_warn = rd_req & hit_warn;
   assign rd_info = rd_req & hit_info;

   // Error reset: accepted only when no cause is present any more
   assign reset_start  = wr_req & hit_err_reset & (I_SC_WDATA[1:0] == CMD_START);
   assign reset_cancel = wr_req & hit_err_reset & (I_SC_WDATA[1:0] != CMD_START);

   assign cause_live = (|(I_ERR_CAUSE & SEVERE_MAPPED_MASK)) | I_VENDOR_FAULT;

   assign reset_ok      = reset_start & ~cause_live;
   assign reset_refused = reset_start & cause_live;

   // Vendor error word, any bit forcing the vendor bit of the severe class
   assign vendor_set = I_VENDOR_FAULT ? VENDOR_GENERAL : CLASS_RESET;
   assign nxt_vendor = (reset_ok ? CLASS_RESET : vendor_ff) | vendor_set;

   assign severe_set = (I_ERR_CAUSE & SEVERE_MAPPED_MASK)
                     | ((|nxt_vendor) ? CLASS_VENDOR_MASK : CLASS_RESET);
   assign nxt_severe = (reset_ok ? CLASS_RESET : severe_ff) | severe_set;

   // Interface status latches communication faults
   assign iface_set = I_ERR_CAUSE[CLASS_COMM_BIT] ? IFACE_COMM_FAULT : CLASS_RESET;
   assign nxt_iface = (reset_ok ? CLASS_RESET : iface_ff) | iface_set;

   // Diagnostic message holds the code of the error that started the fault
   assign first_error = (severe_ff == CLASS_RESET) & (severe_set != CLASS_RESET);
   assign nxt_diag    = reset_ok    ? CLASS_RESET :
                        first_error ? I_ERR_CODE :
                        diag_ff;

   // Severe change bit: set on any change, cleared only by a good reset
   assign severe_evt     = (nxt_severe != severe_ff) & ~reset_ok;
   assign nxt_severe_chg = (reset_ok ? 1'b0 : severe_chg_ff) | severe_evt;

   // Warning class latches until read; a cause in the read cycle survives
   assign warn_in  = I_WARN_CAUSE | (I_VENDOR_WARN ? CLASS_VENDOR_MASK : CLASS_RESET);
   assign nxt_warn = (rd_warn ? CLASS_RESET : warn_ff) | warn_in;

   // Bits cleared by the read itself are not counted as a change
   assign warn_evt     = |(warn_in & ~warn_ff & mask_warn_ff);
   assign nxt_warn_chg = (rd_warn ? 1'b0 : warn_chg_ff) | warn_evt;

   // Info class follows its conditions
   assign info_in  = I_INFO_COND | (I_VENDOR_INFO ? CLASS_VENDOR_MASK : CLASS_RESET);
   assign nxt_info = info_in;

   assign info_evt     = |((info_in ^ info_ff) & mask_info_ff);
   assign nxt_info_chg = (rd_info ? 1'b0 : info_chg_ff) | info_evt;

   // Mask parameters
   assign nxt_mask_warn = (wr_req & hit_mask_warn) ? I_SC_WDATA : mask_warn_ff;
   assign nxt_mask_info = (wr_req & hit_mask_info) ? I_SC_WDATA : mask_info_ff;

   // Procedure command status
   assign nxt_cmd = reset_ok      ? CMD_DONE :
                    reset_refused ? CMD_FAIL :
                    reset_cancel  ? CMD_IDLE :
                    cmd_ff;

   // Shut-down state after this edge, so bit 13 rises together with quick stop
   assign shutdown_next = (shutdown | (|severe_ff)) & ~reset_ok;

   // Cyclic drive status word; bit 13 merges info change and shut-down
   always_comb begin
      nxt_status                     = 16'h0000;
      nxt_status[STS_SEVERE_CHG_BIT] = nxt_severe_chg;
      nxt_status[STS_WARN_CHG_BIT]   = nxt_warn_chg;
      nxt_status[STS_INFO_CHG_BIT]   = nxt_info_chg;
      if (shutdown_next) begin
         nxt_status[STS_SHUTDOWN_BIT] = 1'b1;
      end
   end

   ddem_shutdown u_shutdown (
      .i_clk        (I_CORE_CLK),
      .i_srst       (I_SRST),
      .i_fault      (|severe_ff),
      .i_standstill (I_STANDSTILL),
      .i_release    (reset_ok),
      .o_quick_stop (O_QUICK_STOP),
      .o_power_en   (O_POWER_EN),
      .o_shutdown   (shutdown)
   );

   // Latched severe error and vendor word
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         severe_ff     <= CLASS_RESET;
         vendor_ff     <= CLASS_RESET;
      end else begin
         severe_ff     <= nxt_severe;
         vendor_ff     <= nxt_vendor;
      end
   end

   // Interface status and diagnostic message
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         iface_ff      <= CLASS_RESET;
         diag_ff       <= CLASS_RESET;
      end else begin
         iface_ff      <= nxt_iface;
         diag_ff       <= nxt_diag;
      end
   end

   // Warning and info classes
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         warn_ff       <= CLASS_RESET;
         info_ff       <= CLASS_RESET;
      end else begin
         warn_ff       <= nxt_warn;
         info_ff       <= nxt_info;
      end
   end

   // Change-bit masks
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         mask_warn_ff  <= MASK_RESET;
         mask_info_ff  <= MASK_RESET;
      end else begin
         mask_warn_ff  <= nxt_mask_warn;
         mask_info_ff  <= nxt_mask_info;
      end
   end

   // Error-reset command status
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         cmd_ff        <= CMD_IDLE;
      end else begin
         cmd_ff        <= nxt_cmd;
      end
   end

   // Change bits
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         severe_chg_ff <= 1'b0;
         warn_chg_ff   <= 1'b0;
         info_chg_ff   <= 1'b0;
      end else begin
         severe_chg_ff <= nxt_severe_chg;
         warn_chg_ff   <= nxt_warn_chg;
         info_chg_ff   <= nxt_info_chg;
      end
   end

   // Outputs and service-channel answer
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         O_SC_ACK      <= 1'b0;
         O_SC_ERR      <= 1'b0;
      end else begin
         O_SC_ACK      <= I_SC_REQ;
         O_SC_ERR      <= rd_req ? ~rd_hit : (wr_req & ~wr_hit);
      end
   end

   // Read data stands only with the answer to a read
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         O_SC_RDATA    <= 16'h0000;
      end else begin
         O_SC_RDATA    <= rd_req ? rd_val : 16'h0000;
      end
   end

   // Cyclic status word and command status
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         O_STATUS_WORD <= 16'h0000;
         O_CMD_STATUS  <= CMD_IDLE;
      end else begin
         O_STATUS_WORD <= nxt_status;
         O_CMD_STATUS  <= nxt_cmd;
      end
   end

endmodule // ddem_top

/* testbench/ddem_master.sv */
// Purpose: Behavioural fieldbus master on the service channel
// Assumes: One-cycle request pulse, answer on a following edge
// Notes:   Idle address and data are scrambled so stale values never look valid
`timescale 1ns/10ps

module ddem_master (
   input  wire logic        i_clk,
   output logic             o_req,
   output logic             o_wr,
   output logic      [15:0] o_idn,
   output logic      [15:0] o_wdata,
   input  wire logic        i_ack,
   input  wire logic [15:0] i_rdata,
   input  wire logic        i_err
);
   initial begin
      o_req   = 1'b0;
      o_wr    = 1'b0;
      o_idn   = 16'h5A5A;
      o_wdata = 16'hA5A5;
   end

   // Fetch or command one parameter; gives up unless the answer comes within four edges
   task automatic xfer(input logic w, input logic [15:0] idn, input logic [15:0] wd,
                       output logic [15:0] rd, output logic er, output bit ok);
      ok = 1'b0;
      @(posedge i_clk);
      #1;
      o_req   = 1'b1;
      o_wr    = w;
      o_idn   = idn;
      o_wdata = wd;
      @(posedge i_clk);
      #1;
      o_req   = 1'b0;
      o_wr    = ~w;
      o_idn   = ~idn;
      o_wdata = ~wd;
      for (int n = 0; n < 4 && !ok; n++) begin
         if (i_ack === 1'b1) begin
            rd = i_rdata;
            er = i_err;
            ok = 1'b1;
         end else begin
            @(posedge i_clk);
            #1;
         end
      end
   endtask
endmodule // ddem_master

/* testbench/ddem_top_bench.sv */
// Purpose: Directed bench of the diagnostic manager
// Assumes: 10 MHz core clock, inputs driven 1 ns after the rising edge
// Notes:   Service accesses go through the master model
`timescale 1ns/10ps

module ddem_top_bench
   import ddem_pkg::*;
;
   logic        clk, srst, req, wr, vfault, vwarn, vinfo, still;
   logic        ack, sc_err, qstop, pwr;
   logic [15:0] idn, wdata, cause, code, warn, info, rdata, status;
   logic [1:0]  cmd;
   int          err_total = 0;
   int          num_checks = 0;

   ddem_top DUT (.I_CORE_CLK(clk), .I_SRST(srst), .I_SC_REQ(req), .I_SC_WR(wr),
      .I_SC_IDN(idn), .I_SC_WDATA(wdata), .I_ERR_CAUSE(cause), .I_VENDOR_FAULT(vfault),
      .I_ERR_CODE(code), .I_WARN_CAUSE(warn), .I_VENDOR_WARN(vwarn), .I_INFO_COND(info),
      .I_VENDOR_INFO(vinfo), .I_STANDSTILL(still), .O_SC_ACK(ack), .O_SC_RDATA(rdata),
      .O_SC_ERR(sc_err), .O_STATUS_WORD(status), .O_CMD_STATUS(cmd),
      .O_QUICK_STOP(qstop), .O_POWER_EN(pwr));
   ddem_master M (.i_clk(clk), .o_req(req), .o_wr(wr), .o_idn(idn), .o_wdata(wdata),
      .i_ack(ack), .i_rdata(rdata), .i_err(sc_err));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", nm, exp, got);
         err_total++;
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One access; read data is compared on reads only
   task automatic sc(input logic w, input logic [15:0] i, input logic [15:0] wd,
                     input logic [15:0] exp, input logic eerr);
      logic [15:0] d;
      logic        e;
      bit          ok;
      M.xfer(w, i, wd, d, e, ok);
      if (!ok) begin
         $display("unexpected ack expected 1 seen 0");
         err_total++;
         close_out();
      end
      if (!w)
         chk("rdata", exp, d);
      chk("sc_err", {15'h0000, eerr}, {15'h0000, e});
   endtask

   task automatic pulse_warn(input logic [15:0] c, input logic v);
      warn  = c;
      vwarn = v;
      cyc(1);
      warn  = 16'h0000;
      vwarn = 1'b0;
      cyc(2);
   endtask

   initial begin
      srst = 1'b1;
      {cause, code, warn, info} = '0;
      {vfault, vwarn, vinfo, still} = '0;
      cyc(6);
      srst = 1'b0;
      cyc(1);
      chk("status", 16'h0000, status);
      chk("power", 16'h0001, {15'h0000, pwr});
      sc(0, 16'h0001, 16'h0000, 16'h0000, 1'b1);
      sc(1, IDN_SEVERE, 16'hFFFF, 16'h0000, 1'b1);
      code  = 16'h0004;
      cause = 16'h1002;
      cyc(4);
      chk("status", 16'h2800, status);
      chk("qstop", 16'h0001, {15'h0000, qstop});
      sc(0, IDN_SEVERE, 16'h0000, 16'h1002, 1'b0);
      sc(0, IDN_DIAG, 16'h0000, 16'h0004, 1'b0);
      sc(0, IDN_IFACE, 16'h0000, 16'h0001, 1'b0);
      chk("status", 16'h2800, status);
      still = 1'b1;
      cyc(3);
      chk("power", 16'h0000, {15'h0000, pwr});
      sc(1, IDN_ERR_RESET, 16'h0003, 16'h0000, 1'b0);
      chk("cmd", 16'h0002, {14'h0000, cmd});
      sc(0, IDN_SEVERE, 16'h0000, 16'h1002, 1'b0);
      cause  = 16'h0000;
      vfault = 1'b1;
      cyc(1);
      vfault = 1'b0;
      cyc(2);
      sc(0, IDN_VENDOR, 16'h0000, 16'h0001, 1'b0);
      sc(0, IDN_SEVERE, 16'h0000, 16'h9002, 1'b0);
      sc(1, IDN_ERR_RESET, 16'h0003, 16'h0000, 1'b0);
      chk("cmd", 16'h0001, {14'h0000, cmd});
      chk("status", 16'h0000, status);
      chk("power", 16'h0001, {15'h0000, pwr});
      sc(0, IDN_SEVERE, 16'h0000, 16'h0000, 1'b0);
      sc(0, IDN_VENDOR, 16'h0000, 16'h0000, 1'b0);
      sc(0, IDN_DIAG, 16'h0000, 16'h0000, 1'b0);
      sc(0, IDN_IFACE, 16'h0000, 16'h0000, 1'b0);
      sc(1, IDN_ERR_RESET, 16'h0000, 16'h0000, 1'b0);
      chk("cmd", 16'h0000, {14'h0000, cmd});
      sc(1, IDN_MASK_WARN, 16'hFFFE, 16'h0000, 1'b0);
      pulse_warn(16'h0001, 1'b0);
      chk("status", 16'h0000, status);
      sc(0, IDN_WARN, 16'h0000, 16'h0001, 1'b0);
      pulse_warn(16'h0002, 1'b0);
      chk("status", 16'h1000, status);
      sc(0, IDN_WARN, 16'h0000, 16'h0002, 1'b0);
      chk("status", 16'h0000, status);
      sc(0, IDN_WARN, 16'h0000, 16'h0000, 1'b0);
      pulse_warn(16'h0000, 1'b1);
      sc(0, IDN_WARN, 16'h0000, 16'h8000, 1'b0);
      chk("status", 16'h0000, status);
      info = 16'h0040;
      cyc(3);
      chk("status", 16'h2000, status);
      sc(0, IDN_INFO, 16'h0000, 16'h0040, 1'b0);
      chk("status", 16'h0000, status);
      info = 16'h0000;
      cyc(3);
      chk("status", 16'h2000, status);
      sc(0, IDN_INFO, 16'h0000, 16'h0000, 1'b0);
      sc(1, IDN_MASK_INFO, 16'h7FFF, 16'h0000, 1'b0);
      vinfo = 1'b1;
      cyc(3);
      chk("status", 16'h0000, status);
      sc(0, IDN_INFO, 16'h0000, 16'h8000, 1'b0);
      srst = 1'b1;
      cyc(2);
      srst = 1'b0;
      cyc(1);
      sc(0, IDN_MASK_WARN, 16'h0000, 16'hFFFF, 1'b0);
      close_out();
   end
endmodule // ddem_top_bench

/* testbench/ddem_top_sva.sv */
// Purpose: Port-level checks of the diagnostic manager
// Assumes: One core clock, synchronous active-high reset
// Notes:   Bound to every ddem_top instance
`timescale 1ns/10ps

module ddem_top_sva
   import ddem_pkg::*;
(
   input wire logic        I_CORE_CLK,
   input wire logic        I_SRST,
   input wire logic        I_SC_REQ,
   input wire logic        I_SC_WR,
   input wire logic [15:0] I_SC_IDN,
   input wire logic [15:0] I_SC_WDATA,
   input wire logic [15:0] I_ERR_CAUSE,
   input wire logic        I_VENDOR_FAULT,
   input wire logic [15:0] I_WARN_CAUSE,
   input wire logic        I_VENDOR_WARN,
   input wire logic        I_STANDSTILL,
   input wire logic        O_SC_ACK,
   input wire logic        O_SC_ERR,
   input wire logic [15:0] O_STATUS_WORD,
   input wire logic [1:0]  O_CMD_STATUS,
   input wire logic        O_QUICK_STOP,
   input wire logic        O_POWER_EN
);
   wire cmd_go = I_SC_REQ && I_SC_WR && (I_SC_IDN == IDN_ERR_RESET)
                 && (I_SC_WDATA[1:0] == CMD_START);
   wire cause  = ((I_ERR_CAUSE & SEVERE_MAPPED_MASK) != 16'h0000) || I_VENDOR_FAULT;
   wire wrd    = I_SC_REQ && !I_SC_WR && (I_SC_IDN == IDN_WARN);
   wire wquiet = (I_WARN_CAUSE == 16'h0000) && !I_VENDOR_WARN;

   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SRST);

   AST_ACK: assert property (I_SC_REQ |=> O_SC_ACK)
      else $error("request not answered");
   AST_SEV_SET: assert property (cause |=> O_STATUS_WORD[11])
      else $error("severe change bit missing");
   AST_SEV_HOLD: assert property (O_STATUS_WORD[11] && !cmd_go |=> O_STATUS_WORD[11])
      else $error("severe change bit dropped");
   AST_CMD_OK: assert property (cmd_go && !cause |=> (O_CMD_STATUS == CMD_DONE)
      && !O_STATUS_WORD[11] && O_POWER_EN && !O_QUICK_STOP)
      else $error("good error reset not executed");
   AST_CMD_FAIL: assert property (cmd_go && cause |=> (O_CMD_STATUS == CMD_FAIL)
      && O_STATUS_WORD[11])
      else $error("refused error reset changed state");
   AST_SHUTDOWN: assert property ($rose(O_STATUS_WORD[11]) |=> O_QUICK_STOP
      && O_STATUS_WORD[13])
      else $error("quick stop or shut-down bit missing");
   AST_POWER_OFF: assert property (O_QUICK_STOP && I_STANDSTILL && !cmd_go |=> !O_POWER_EN)
      else $error("power stage not switched off");
   AST_WARN_RD: assert property (wrd && wquiet |=> !O_STATUS_WORD[12])
      else $error("warning change bit not cleared by read");
   AST_RO_WRITE: assert property (I_SC_REQ && I_SC_WR && (I_SC_IDN == IDN_SEVERE)
      |=> O_SC_ERR)
      else $error("write to severe class accepted");
endmodule // ddem_top_sva

bind ddem_top ddem_top_sva u_sva (
   .I_CORE_CLK(I_CORE_CLK), .I_SRST(I_SRST), .I_SC_REQ(I_SC_REQ), .I_SC_WR(I_SC_WR),
   .I_SC_IDN(I_SC_IDN), .I_SC_WDATA(I_SC_WDATA), .I_ERR_CAUSE(I_ERR_CAUSE),
   .I_VENDOR_FAULT(I_VENDOR_FAULT), .I_WARN_CAUSE(I_WARN_CAUSE),
   .I_VENDOR_WARN(I_VENDOR_WARN), .I_STANDSTILL(I_STANDSTILL), .O_SC_ACK(O_SC_ACK),
   .O_SC_ERR(O_SC_ERR), .O_STATUS_WORD(O_STATUS_WORD), .O_CMD_STATUS(O_CMD_STATUS),
   .O_QUICK_STOP(O_QUICK_STOP), .O_POWER_EN(O_POWER_EN)
);
